// File: hw/t1pm_status_page.sv
// Performance monitor status page: counters, sticky latches, bus slave
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Wrapping event counter with wrap pulse
// ------------------------------------------------------------
module t1pm_cnt #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_inc,
  input  wire logic         i_clr,
  output logic [W-1:0]      o_val,
  output logic              o_wrap
);
  // Clear beats a count in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_val <= '0;
    end else if (i_clr) begin
      o_val <= '0;
    end else if (i_inc) begin
      o_val <= o_val + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // Wrap from all ones to zero
  always_comb begin
    o_wrap = i_inc && !i_clr && (&o_val);
  end
endmodule // t1pm_cnt

// ------------------------------------------------------------
// Status page top
// ------------------------------------------------------------
module t1pm_status_page
  import t1pm_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // Parallel register bus
  input  wire logic [7:0]   i_page,
  input  wire logic         i_cs_b,
  input  wire logic         i_rd_stb,
  input  wire logic         i_wr_stb,
  input  wire logic [4:0]   i_addr,
  input  wire logic [7:0]   i_wdata,
  output logic [7:0]        o_rdata,
  output logic              o_rdata_oe_b,
  // Framer events and modes
  input  wire t1pm_evt_s    i_evt,
  input  wire logic         i_in_sync,
  input  wire logic         i_ext_mode,
  input  wire logic         i_fs_watch,
  input  wire logic [31:0]  i_irq_set
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic       sel;
  logic       rd;
  logic       wr;
  logic       rd_alarm;
  logic       rd_overflow;
  logic       rd_viol_hi;
  logic       rd_viol_lo;
  logic       rd_crc_hi;
  logic       rd_crc_lo;
  logic [3:0] rd_irq;

  // Page and upper half of the five-bit space
  always_comb begin
    sel = !i_cs_b && (i_page == T1PM_PAGE) && i_addr[4];
    rd  = sel && i_rd_stb;
    wr  = sel && i_wr_stb;
  end

  // Per-register read strobes for read side effects
  always_comb begin
    rd_alarm    = rd && (i_addr == T1PM_A_ALARM);
    rd_overflow = rd && (i_addr == T1PM_A_OVERFLOW);
    rd_viol_hi  = rd && (i_addr == T1PM_A_LINE_VIOL_HI);
    rd_viol_lo  = rd && (i_addr == T1PM_A_LINE_VIOL_LO);
    rd_crc_hi   = rd && (i_addr == T1PM_A_CRC_ERR_HI);
    rd_crc_lo   = rd && (i_addr == T1PM_A_CRC_ERR_LO);
    rd_irq[0]   = rd && (i_addr == T1PM_A_IRQ0);
    rd_irq[1]   = rd && (i_addr == T1PM_A_IRQ1);
    rd_irq[2]   = rd && (i_addr == T1PM_A_IRQ2);
    rd_irq[3]   = rd && (i_addr == T1PM_A_IRQ3);
  end

  // ------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------
  logic [7:0]  prbs_err_cnt;
  logic [7:0]  prbs_mf_cnt;
  logic [7:0]  framing_err_cnt;
  logic [3:0]  frame_loss_cnt;
  logic [3:0]  realign_cnt;
  logic [7:0]  mf_sync_loss_cnt;
  logic [15:0] line_violation_cnt;
  logic [15:0] crc_err_cnt;
  logic [7:0]  wraps;
  logic        wrap_prbs;
  logic        wrap_framing;
  logic        wrap_loss;
  logic        wrap_realign;
  logic        wrap_mf_loss;
  logic        wrap_line_viol;
  logic        wrap_crc;
  logic        prbs_wr;
  logic        fbit_err;

  always_comb begin
    prbs_wr = wr && (i_addr == T1PM_A_PRBS_ERR);
    // Framing bit source by format, gated by sync
    fbit_err = i_in_sync && (i_ext_mode ? i_evt.ext_fbit_err
             : (i_evt.ft_err || (i_fs_watch && i_evt.fs_err)));
  end

  // PRBS error count, host writable
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prbs_err_cnt <= T1PM_RST_BYTE;
    end else if (prbs_wr) begin
      prbs_err_cnt <= i_wdata;
    end else if (i_evt.prbs_err) begin
      prbs_err_cnt <= prbs_err_cnt + 8'h01;
    end
  end

  // Host load never counts as a wrap
  always_comb begin
    wrap_prbs = !prbs_wr && i_evt.prbs_err && (&prbs_err_cnt);
  end

  // Multiframe reference count
  t1pm_cnt #(.W(8)) u_prbs_mf (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_inc   (i_evt.crc_mf),
    .i_clr   (prbs_wr),
    .o_val   (prbs_mf_cnt),
    .o_wrap  ()
  );

  // Framing bit error count
  t1pm_cnt #(.W(8)) u_framing (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_inc   (fbit_err),
    .i_clr   (1'b0),
    .o_val   (framing_err_cnt),
    .o_wrap  (wrap_framing)
  );

  // Frame loss nibble
  t1pm_cnt #(.W(4)) u_loss (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_inc   (i_evt.frame_loss),
    .i_clr   (1'b0),
    .o_val   (frame_loss_cnt),
    .o_wrap  (wrap_loss)
  );

  // Alignment change nibble
  t1pm_cnt #(.W(4)) u_realign (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_inc   (i_evt.realign),
    .i_clr   (1'b0),
    .o_val   (realign_cnt),
    .o_wrap  (wrap_realign)
  );

  // Multiframe sync loss count
  t1pm_cnt #(.W(8)) u_mf_loss (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_inc   (i_evt.mf_sync_loss),
    .i_clr   (1'b0),
    .o_val   (mf_sync_loss_cnt),
    .o_wrap  (wrap_mf_loss)
  );

  // Bipolar violation count, sixteen bits
  t1pm_cnt #(.W(16)) u_line_viol (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_inc   (i_evt.line_viol),
    .i_clr   (1'b0),
    .o_val   (line_violation_cnt),
    .o_wrap  (wrap_line_viol)
  );

  // CRC-6 error count, sixteen bits
  t1pm_cnt #(.W(16)) u_crc (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_inc   (i_evt.crc_err),
    .i_clr   (1'b0),
    .o_val   (crc_err_cnt),
    .o_wrap  (wrap_crc)
  );

  // Overflow events in latch bit order; bit 0 has no counter
  always_comb begin
    wraps                    = 8'h00;
    wraps[T1PM_OV_FRAMING]   = wrap_framing;
    wraps[T1PM_OV_CRC]       = wrap_crc;
    wraps[T1PM_OV_LOSS]      = wrap_loss;
    wraps[T1PM_OV_REALIGN]   = wrap_realign;
    wraps[T1PM_OV_LINE_VIOL] = wrap_line_viol;
    wraps[T1PM_OV_PRBS]      = wrap_prbs;
    wraps[T1PM_OV_MF_LOSS]   = wrap_mf_loss;
  end

  // ------------------------------------------------------------
  // Sticky latches, cleared by read, set wins over clear
  // ------------------------------------------------------------
  logic [7:0]  alarm_report_latch;
  logic [7:0]  alarm_set;
  logic [31:0] irq_status;
  logic [7:0]  counter_overflow_latch;

  always_comb begin
    alarm_set = {i_evt.yellow_long,
                 i_evt.yellow_short,
                 i_evt.yellow_sec,
                 i_evt.yellow_ext,
                 i_evt.all_ones,
                 i_evt.density_viol,
                 i_evt.lb_on_code,
                 i_evt.lb_off_code};
  end

  // Alarm latch
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      alarm_report_latch <= T1PM_RST_BYTE;
    end else begin
      alarm_report_latch <= (rd_alarm ? 8'h00
                            : alarm_report_latch) | alarm_set;
    end
  end

  // Interrupt words, byte k at offset IRQ0 plus k
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_status <= 32'h0000_0000;
    end else begin
      for (int k = 0; k < 4; k++) begin
        irq_status[8*k +: 8] <= (rd_irq[k] ? 8'h00
                                : irq_status[8*k +: 8]) | i_irq_set[8*k +: 8];
      end
    end
  end

  // Overflow latch
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      counter_overflow_latch <= T1PM_RST_BYTE;
    end else begin
      counter_overflow_latch <= (rd_overflow ? 8'h00
                                : counter_overflow_latch) | wraps;
    end
  end

  // ------------------------------------------------------------
  // Coherent low bytes of the sixteen-bit counts
  // ------------------------------------------------------------
  logic [7:0] line_viol_lo_hold;
  logic [7:0] crc_lo_hold;
  logic       line_viol_held;
  logic       crc_held;

  // High byte read freezes the matching low byte
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_viol_lo_hold <= T1PM_RST_BYTE;
      line_viol_held    <= 1'b0;
    end else if (rd_viol_hi) begin
      line_viol_lo_hold <= line_violation_cnt[7:0];
      line_viol_held    <= 1'b1;
    end else if (rd_viol_lo) begin
      line_viol_held    <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      crc_lo_hold <= T1PM_RST_BYTE;
      crc_held    <= 1'b0;
    end else if (rd_crc_hi) begin
      crc_lo_hold <= crc_err_cnt[7:0];
      crc_held    <= 1'b1;
    end else if (rd_crc_lo) begin
      crc_held    <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read mux and registered read port
  // ------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    case (i_addr)
      T1PM_A_PRBS_ERR:     next_rdata = prbs_err_cnt;
      T1PM_A_PRBS_MF:      next_rdata = prbs_mf_cnt;
      T1PM_A_ALARM:        next_rdata = alarm_report_latch;
      T1PM_A_FRAMING_ERR:  next_rdata = framing_err_cnt;
      T1PM_A_LOSS_REALIGN: next_rdata = {frame_loss_cnt, realign_cnt};
      T1PM_A_MF_SYNC_LOSS: next_rdata = mf_sync_loss_cnt;
      T1PM_A_LINE_VIOL_HI: next_rdata = line_violation_cnt[15:8];
      T1PM_A_LINE_VIOL_LO: next_rdata = line_viol_held ? line_viol_lo_hold
                                        : line_violation_cnt[7:0];
      T1PM_A_CRC_ERR_HI:   next_rdata = crc_err_cnt[15:8];
      T1PM_A_CRC_ERR_LO:   next_rdata = crc_held ? crc_lo_hold : crc_err_cnt[7:0];
      T1PM_A_IRQ0:         next_rdata = irq_status[7:0];
      T1PM_A_IRQ1:         next_rdata = irq_status[15:8];
      T1PM_A_IRQ2:         next_rdata = irq_status[23:16];
      T1PM_A_IRQ3:         next_rdata = irq_status[31:24];
      T1PM_A_OVERFLOW:     next_rdata = counter_overflow_latch;
      default:             next_rdata = 8'h00;
    endcase
  end

  // Snapshot at the read strobe, held until the next read
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= T1PM_RST_BYTE;
    end else if (rd) begin
      o_rdata <= next_rdata;
    end
  end

  // Drive enable, low for one cycle after a read
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata_oe_b <= 1'b1;
    end else begin
      o_rdata_oe_b <= !rd;
    end
  end

endmodule // t1pm_status_page
`default_nettype wire

// File: hw/t1pm_pkg.sv
// Constants, field layout and event carrier for the T1 status page
package t1pm_pkg;

  // ------------------------------------------------------------
  // Page and register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] T1PM_PAGE            = 8'h04;
  localparam logic [4:0] T1PM_A_PRBS_ERR      = 5'h10;
  localparam logic [4:0] T1PM_A_PRBS_MF       = 5'h11;
  localparam logic [4:0] T1PM_A_ALARM         = 5'h12;
  localparam logic [4:0] T1PM_A_FRAMING_ERR   = 5'h13;
  localparam logic [4:0] T1PM_A_LOSS_REALIGN  = 5'h14;
  localparam logic [4:0] T1PM_A_MF_SYNC_LOSS  = 5'h15;
  localparam logic [4:0] T1PM_A_LINE_VIOL_HI  = 5'h16;
  localparam logic [4:0] T1PM_A_LINE_VIOL_LO  = 5'h17;
  localparam logic [4:0] T1PM_A_CRC_ERR_HI    = 5'h18;
  localparam logic [4:0] T1PM_A_CRC_ERR_LO    = 5'h19;
  localparam logic [4:0] T1PM_A_UNUSED        = 5'h1A;
  localparam logic [4:0] T1PM_A_IRQ0          = 5'h1B;
  localparam logic [4:0] T1PM_A_IRQ1          = 5'h1C;
  localparam logic [4:0] T1PM_A_IRQ2          = 5'h1D;
  localparam logic [4:0] T1PM_A_IRQ3          = 5'h1E;
  localparam logic [4:0] T1PM_A_OVERFLOW      = 5'h1F;

  // ------------------------------------------------------------
  // Overflow latch bit positions
  // ------------------------------------------------------------
  localparam int T1PM_OV_FRAMING   = 7;
  localparam int T1PM_OV_CRC       = 6;
  localparam int T1PM_OV_LOSS      = 5;
  localparam int T1PM_OV_REALIGN   = 4;
  localparam int T1PM_OV_LINE_VIOL = 3;
  localparam int T1PM_OV_PRBS      = 2;
  localparam int T1PM_OV_MF_LOSS   = 1;

  // Reset values
  localparam logic [7:0] T1PM_RST_BYTE = 8'h00;

  // ------------------------------------------------------------
  // One-cycle detection pulses from the receive framer
  // ------------------------------------------------------------
  typedef struct packed {
    logic prbs_err;      // Pattern error at the checker
    logic crc_mf;        // CRC multiframe received
    logic yellow_long;   // Yellow seen in 600 ms window
    logic yellow_short;  // Yellow seen in 48 ms window
    logic yellow_sec;    // S bit yellow, frame 12
    logic yellow_ext;    // Extended superframe yellow
    logic all_ones;      // Blue alarm
    logic density_viol;  // Pulse density violation
    logic lb_on_code;    // Loopback enable code
    logic lb_off_code;   // Loopback disable code
    logic ft_err;        // Ft framing bit error
    logic fs_err;        // Fs framing bit error
    logic ext_fbit_err;  // Extended superframe framing bit error
    logic frame_loss;    // Frame sync lost
    logic realign;       // Resync ended at new alignment
    logic mf_sync_loss;  // Multiframe with sync lost
    logic line_viol;     // Bipolar violation
    logic crc_err;       // CRC-6 error
  } t1pm_evt_s;

endpackage

// File: tb/t1pm_status_page_chk.sv
// Bus and counter checker for the status page
`timescale 1ns/1ps
`default_nettype none
module t1pm_status_page_chk
  import t1pm_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic [7:0] i_page,
  input wire logic       i_cs_b,
  input wire logic       i_rd_stb,
  input wire logic       i_wr_stb,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_rdata_oe_b,
  input wire t1pm_evt_s  i_evt,
  input wire logic       i_in_sync
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Decoded requests; alarm pulses in latch bit order
  wire logic       sel = !i_cs_b && i_page == T1PM_PAGE && i_addr[4];
  wire logic       rd  = sel && i_rd_stb;
  wire logic       wr0 = sel && i_wr_stb && i_addr == T1PM_A_PRBS_ERR;
  wire logic [7:0] alm = i_evt[15:8];

  property p_oe_low;
    rd |=> !o_rdata_oe_b;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("oe not low after read");
  property p_oe_high;
    !rd |=> o_rdata_oe_b && $stable(o_rdata);
  endproperty
  a_oe_high: assert property (p_oe_high) else $error("bus moved without read");
  property p_unused;
    rd && i_addr == T1PM_A_UNUSED |=> o_rdata == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused place not zero");
  property p_alarm_set;
    (alm != 8'h00) ##1 (rd && i_addr == T1PM_A_ALARM) |=> (o_rdata & $past(alm, 2)) == $past(alm, 2);
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm not latched");
  property p_alarm_clear;
    (rd && i_addr == T1PM_A_ALARM && alm == 8'h00) ##1 (rd && i_addr == T1PM_A_ALARM && alm == 8'h00)
      |=> o_rdata == 8'h00;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared");
  property p_prbs_inc;
    (rd && i_addr == T1PM_A_PRBS_ERR && i_evt.prbs_err && !wr0) ##1 (rd && i_addr == T1PM_A_PRBS_ERR)
      |=> o_rdata == $past(o_rdata) + 8'h01;
  endproperty
  a_prbs_inc: assert property (p_prbs_inc) else $error("pattern count step wrong");
  property p_mf_clear;
    wr0 ##1 (rd && i_addr == T1PM_A_PRBS_MF) |=> o_rdata == 8'h00;
  endproperty
  a_mf_clear: assert property (p_mf_clear) else $error("multiframe count not cleared");
  property p_frame_hold;
    (rd && i_addr == T1PM_A_FRAMING_ERR && !i_in_sync && i_evt[7:5] != 3'b000)
      ##1 (rd && i_addr == T1PM_A_FRAMING_ERR) |=> $stable(o_rdata);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("framing count moved out of sync");
  property p_loss_inc;
    (rd && i_addr == T1PM_A_LOSS_REALIGN && i_evt.frame_loss) ##1 (rd && i_addr == T1PM_A_LOSS_REALIGN)
      |=> o_rdata[7:4] == $past(o_rdata[7:4]) + 4'h1;
  endproperty
  a_loss_inc: assert property (p_loss_inc) else $error("frame loss count step wrong");
endmodule // t1pm_status_page_chk

bind t1pm_status_page t1pm_status_page_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_page(i_page), .i_cs_b(i_cs_b), .i_rd_stb(i_rd_stb), .i_wr_stb(i_wr_stb), .i_addr(i_addr),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rdata_oe_b(o_rdata_oe_b), .i_evt(i_evt),
  .i_in_sync(i_in_sync));
`default_nettype wire

// File: tb/t1pm_host.sv
// Host processor model on the parallel register bus
`timescale 1ns/1ps
`default_nettype none
module t1pm_host
  import t1pm_pkg::*;
(
  // Clock and read data
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  // Bus requests
  output var logic [7:0]  o_page,
  output var logic        o_cs_b,
  output var logic        o_rd_stb,
  output var logic        o_wr_stb,
  output var logic [4:0]  o_addr,
  output var logic [7:0]  o_wdata
);
  // Released address and data lines never keep their last value
  task automatic idle();
    o_cs_b = 1'b1;
    o_rd_stb = 1'b0;
    o_wr_stb = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask
  // One write, called at a falling edge; a read must follow at once
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    o_cs_b = 1'b0;
    o_rd_stb = 1'b0;
    o_wr_stb = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // One or two back-to-back reads; data lands a cycle later
  task automatic rd(input logic [4:0] a, input int n, output logic [7:0] d0,
                    output logic [7:0] d1);
    o_cs_b = 1'b0;
    o_rd_stb = 1'b1;
    o_wr_stb = 1'b0;
    o_addr = a;
    @(posedge i_clk);
    @(negedge i_clk);
    d0 = i_rdata;
    if (n > 1) begin
      @(posedge i_clk);
      @(negedge i_clk);
    end
    idle();
    @(posedge i_clk);
    @(negedge i_clk);
    d1 = i_rdata;
  endtask
  // Idle bus at time zero on this page
  initial begin
    o_page = T1PM_PAGE;
    o_addr = 5'h00;
    o_wdata = 8'h00;
    idle();
  end
endmodule // t1pm_host
`default_nettype wire

// File: tb/test_t1pm_status_page.sv
// Self-checking bench for the status page
`timescale 1ns/1ps
`default_nettype none
module test_t1pm_status_page
  import t1pm_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        in_sync = 1'b1;
  logic        ext_mode = 1'b0;
  logic        fs_watch = 1'b0;
  logic [31:0] irq = 32'h0;
  t1pm_evt_s   evt = '0;
  t1pm_evt_s   e;
  logic [7:0]  page, wdata, rdata, d0, d1;
  logic [4:0]  addr;
  logic        cs_b, rd_stb, wr_stb;
  int          errors = 0;
  int          checked = 0;
  // Clock and one-cycle event pulses
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    evt <= '0;
    irq <= '0;
  end
  t1pm_host u_host (.i_clk(clk), .i_rdata(rdata), .o_page(page), .o_cs_b(cs_b),
    .o_rd_stb(rd_stb), .o_wr_stb(wr_stb), .o_addr(addr), .o_wdata(wdata));
  t1pm_status_page i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_page(page), .i_cs_b(cs_b),
    .i_rd_stb(rd_stb), .i_wr_stb(wr_stb), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .o_rdata_oe_b(), .i_evt(evt), .i_in_sync(in_sync), .i_ext_mode(ext_mode),
    .i_fs_watch(fs_watch), .i_irq_set(irq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic pr(input t1pm_evt_s ev, input logic [4:0] a, input int n);
    evt = ev;
    u_host.rd(a, n, d0, d1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int a = 16; a < 32; a++) begin
      pr('0, 5'(a), 2);
      chk("reset", d0, T1PM_RST_BYTE);
      chk("reset", d1, T1PM_RST_BYTE);
    end
    $display("reset done");
  endtask
  task automatic t_alarm();
    for (int i = 0; i < 8; i++) begin
      pr(t1pm_evt_s'({2'b00, 8'h01 << i, 8'h00}), T1PM_A_ALARM, 2);
      chk("alarm old", d0, 8'h00);
      chk("alarm set", d1, 8'h01 << i);
      pr('0, T1PM_A_ALARM, 1);
      chk("alarm clr", d1, 8'h00);
    end
    $display("alarm done");
  endtask
  task automatic t_prbs();
    e = '0;
    e.prbs_err = 1'b1;
    e.crc_mf = 1'b1;
    u_host.wr(T1PM_A_PRBS_ERR, 8'hFE);
    pr(e, T1PM_A_PRBS_ERR, 2);
    chk("prbs", d0, 8'hFE);
    chk("prbs", d1, 8'hFF);
    e.crc_mf = 1'b0;
    pr(e, T1PM_A_PRBS_ERR, 2);
    chk("prbs wrap", d1, 8'h00);
    pr('0, T1PM_A_PRBS_MF, 1);
    chk("mf", d1, 8'h01);
    pr('0, T1PM_A_OVERFLOW, 1);
    chk("ovf", d1, 8'(1 << T1PM_OV_PRBS));
    e = '0;
    e.crc_mf = 1'b1;
    evt = e;
    u_host.wr(T1PM_A_PRBS_ERR, 8'h00);
    pr('0, T1PM_A_PRBS_MF, 1);
    chk("mf clr", d1, 8'h00);
    $display("prbs done");
  endtask
  task automatic t_frame();
    logic [6:0] cases [6] = '{7'h49, 7'h44, 7'h55, 7'h63, 7'h68, 7'h08};
    logic [7:0] cnt;
    cnt = 8'h00;
    foreach (cases[i]) begin
      {in_sync, ext_mode, fs_watch} = cases[i][6:4];
      pr(t1pm_evt_s'({10'h000, cases[i][3:1], 5'h00}), T1PM_A_FRAMING_ERR, 2);
      chk("frame", d0, cnt);
      cnt = cnt + {7'h00, cases[i][0]};
      chk("frame", d1, cnt);
    end
    in_sync = 1'b1;
    $display("framing done");
  endtask
  task automatic t_loss();
    e = '0;
    e.frame_loss = 1'b1;
    pr(e, T1PM_A_LOSS_REALIGN, 2);
    chk("loss", d1, 8'h10);
    e = '0;
    e.realign = 1'b1;
    pr(e, T1PM_A_LOSS_REALIGN, 2);
    chk("realign", d1, 8'h11);
    $display("loss done");
  endtask
  task automatic t_pair();
    logic [4:0] hi;
    for (int k = 0; k < 2; k++) begin
      e = t1pm_evt_s'(18'h00002 >> k);
      hi = k ? T1PM_A_CRC_ERR_HI : T1PM_A_LINE_VIOL_HI;
      repeat (3) pr(e, T1PM_A_UNUSED, 1);
      pr(e, hi, 1);
      chk("pair hi", d1, 8'h00);
      pr('0, hi + 5'h01, 1);
      chk("pair frozen", d1, 8'h03);
      pr('0, hi + 5'h01, 1);
      chk("pair live", d1, 8'h04);
    end
    $display("pair done");
  endtask
  task automatic t_irq();
    for (int k = 0; k < 4; k++) begin
      irq = 32'h000000A5 << (8 * k);
      pr('0, T1PM_A_IRQ0 + 5'(k), 2);
      chk("irq", d1, 8'hA5);
      pr('0, T1PM_A_IRQ0 + 5'(k), 1);
      chk("irq clr", d1, 8'h00);
    end
    $display("irq done");
  endtask
  task automatic t_page();
    e = '0;
    e.all_ones = 1'b1;
    u_host.o_page = 8'h03;
    pr(e, T1PM_A_ALARM, 1);
    u_host.o_page = T1PM_PAGE;
    u_host.wr(T1PM_A_FRAMING_ERR, 8'h55);
    pr('0, T1PM_A_ALARM, 1);
    chk("page", d1, 8'h08);
    pr('0, T1PM_A_FRAMING_ERR, 1);
    chk("ro", d1, 8'h03);
    $display("page done");
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_alarm();
    t_prbs();
    t_frame();
    t_loss();
    t_pair();
    t_irq();
    t_page();
    wrap_up();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule // test_t1pm_status_page
`default_nettype wire
